// ### sram_link_map.svh
// Named constants for the burst memory link
`ifndef SRAM_LINK_MAP_SVH
`define SRAM_LINK_MAP_SVH
`define SRAM_ADDR_W 20
`define SRAM_DATA_W 36
`define SRAM_LANES 4
`define SRAM_CNT_W 2
`define SRAM_CNT_ZERO 2'h0
`define SRAM_CNT_STEP 2'h1
`define SRAM_FIFO_DEPTH 4
`define SRAM_LOW 1'b0
`define SRAM_HIGH 1'b1
`endif

// ### sram_link_pkg.sv
// Types shared by both ends of the burst memory link
`default_nettype none
package sram_link_pkg;
  typedef enum logic [1:0] {
    OP_IDLE,
    OP_READ,
    OP_WRITE
  } op_type;
endpackage
`default_nettype wire

// ### sram_link_if.sv
// Pin bundle between controller and flow-through burst memory
`timescale 1ns/1ps
`default_nettype none
`include "sram_link_map.svh"
interface sram_link_if #(
  parameter int AW = `SRAM_ADDR_W,
  parameter int DW = `SRAM_DATA_W,
  parameter int LANES = `SRAM_LANES
);
  logic clock_gate_n;
  logic chip_select_first_n;
  logic chip_select_second;
  logic chip_select_third_n;
  logic write_n;
  logic advance_or_load;
  logic [LANES-1:0] byte_lane_write_n;
  logic [AW-1:0] addr;
  logic output_enable_n;
  logic sleep_request;
  logic burst_interleave;
  logic [DW-1:0] host_dq_out;
  logic host_dq_oe;
  logic [DW-1:0] dev_dq_out;
  logic dev_dq_oe;
  logic [DW-1:0] dq;

  // Shared data wire; an undriven bus reads as zero
  assign dq = dev_dq_oe ? dev_dq_out : (host_dq_oe ? host_dq_out : '0);

  modport device (
    input clock_gate_n, chip_select_first_n, chip_select_second, chip_select_third_n,
    input write_n, advance_or_load, byte_lane_write_n, addr, output_enable_n,
    input sleep_request, burst_interleave, dq,
    output dev_dq_out, dev_dq_oe
  );
  modport host (
    output clock_gate_n, chip_select_first_n, chip_select_second, chip_select_third_n,
    output write_n, advance_or_load, byte_lane_write_n, addr, output_enable_n,
    output sleep_request, burst_interleave, host_dq_out, host_dq_oe,
    input dq
  );
endinterface
`default_nettype wire

// ### sram_req_fifo.sv
// Small valid/ready FIFO for queued memory requests
`timescale 1ns/1ps
`default_nettype none
module sram_req_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 4
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [W-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [W-1:0] o_out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [W-1:0] mem_reg [DEPTH];
  logic [PW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic [PW:0] count_reg, count_next;
  logic push, pop;

  assign o_in_ready = (count_reg != DEPTH[PW:0]);
  assign o_out_valid = (count_reg != '0);
  assign o_out_data = mem_reg[rd_ptr_reg];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always_comb
  begin
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    count_next = count_reg;
    if (push)
    begin
      wr_ptr_next = (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
    end
    if (pop)
    begin
      rd_ptr_next = (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
    end
    if (push && !pop)
    begin
      count_next = count_reg + 1'b1;
    end
    else if (pop && !push)
    begin
      count_next = count_reg - 1'b1;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg <= count_next;
    end
  end

  // Storage needs no reset; only valid slots are ever read out
  always_ff @(posedge i_clk)
  begin
    if (push)
    begin
      mem_reg[wr_ptr_reg] <= i_in_data;
    end
  end
endmodule
`default_nettype wire

// ### sram_host_end.sv
// Controller end: queues requests and sequences them onto the memory pins
`timescale 1ns/1ps
`default_nettype none
`include "sram_link_map.svh"
module sram_host_end
  import sram_link_pkg::*;
#(
  parameter int AW = `SRAM_ADDR_W,
  parameter int DW = `SRAM_DATA_W,
  parameter int LANES = `SRAM_LANES,
  parameter int DEPTH = `SRAM_FIFO_DEPTH
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  sram_link_if.host link,
  input wire logic i_req_valid,
  output logic o_req_ready,
  input wire logic i_req_write,
  input wire logic i_req_burst,
  input wire logic [AW-1:0] i_req_addr,
  input wire logic [DW-1:0] i_req_data,
  input wire logic [LANES-1:0] i_req_lanes_n,
  input wire logic i_hold,
  input wire logic i_sleep,
  input wire logic i_interleave,
  input wire logic i_out_en_n,
  output logic o_rd_valid,
  output logic [DW-1:0] o_rd_data
);
  localparam int FW = 2 + AW + DW + LANES;
  logic [FW-1:0] f_data;
  logic f_valid, f_ready, qual;
  logic e_write, e_burst;
  logic [AW-1:0] e_addr;
  logic [DW-1:0] e_data;
  logic [LANES-1:0] e_lanes_n;
  op_type last_reg, last_next, op_now;
  logic gate_n_reg, gate_n_next, sel_reg, sel_next, we_n_reg, we_n_next, adv_reg, adv_next;
  logic sleep_reg, sleep_next, wr_ph_reg, wr_ph_next, rd_ph_reg, rd_ph_next;
  logic rdv_reg, rdv_next;
  logic [AW-1:0] addr_reg, addr_next;
  logic [LANES-1:0] lanes_reg, lanes_next;
  logic [DW-1:0] wd_reg, wd_next, wd_hold_reg, wd_hold_next, rd_reg, rd_next;

  sram_req_fifo #(.W(FW), .DEPTH(DEPTH)) u_fifo (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_in_valid(i_req_valid),
    .o_in_ready(o_req_ready),
    .i_in_data({i_req_write, i_req_burst, i_req_addr, i_req_data, i_req_lanes_n}),
    .o_out_valid(f_valid),
    .i_out_ready(f_ready),
    .o_out_data(f_data)
  );

  assign {e_write, e_burst, e_addr, e_data, e_lanes_n} = f_data;
  // The memory sees an edge only when the gate on the pins is low
  assign qual = !gate_n_reg;
  // Hold requests back while sleep heads for the pins, or the memory drops them
  assign f_ready = qual && !i_sleep;
  assign op_now = e_burst ? last_reg : (e_write ? OP_WRITE : OP_READ);

  always_comb
  begin
    gate_n_next = i_hold;
    sleep_next = i_sleep;
    sel_next = sel_reg;
    we_n_next = we_n_reg;
    adv_next = adv_reg;
    addr_next = addr_reg;
    lanes_next = lanes_reg;
    last_next = last_reg;
    wr_ph_next = wr_ph_reg;
    rd_ph_next = rd_ph_reg;
    wd_next = wd_reg;
    wd_hold_next = wd_hold_reg;
    rdv_next = `SRAM_LOW;
    rd_next = rd_reg;
    if (qual)
    begin
      if (rd_ph_reg)
      begin
        rdv_next = `SRAM_HIGH;
        rd_next = link.dq;
      end
      wd_next = wd_hold_reg;
      wr_ph_next = (last_reg == OP_WRITE) && sel_reg;
      rd_ph_next = (last_reg == OP_READ) && sel_reg;
      if (f_valid && !i_sleep)
      begin
        // Back-to-back reads and writes go out with no idle cycle between
        sel_next = `SRAM_HIGH;
        we_n_next = (op_now != OP_WRITE);
        adv_next = e_burst;
        addr_next = e_addr;
        lanes_next = e_lanes_n;
        wd_hold_next = e_data;
        last_next = (e_burst && last_reg == OP_IDLE) ? OP_IDLE : op_now;
      end
      else
      begin
        // Deselect drops the burst, so the next access must load an address
        sel_next = `SRAM_LOW;
        we_n_next = `SRAM_HIGH;
        adv_next = `SRAM_LOW;
        lanes_next = '1;
        last_next = OP_IDLE;
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      gate_n_reg <= `SRAM_LOW;
      sleep_reg <= `SRAM_LOW;
      sel_reg <= `SRAM_LOW;
      we_n_reg <= `SRAM_HIGH;
      adv_reg <= `SRAM_LOW;
      addr_reg <= '0;
      lanes_reg <= '1;
      last_reg <= OP_IDLE;
      wr_ph_reg <= `SRAM_LOW;
      rd_ph_reg <= `SRAM_LOW;
      wd_reg <= '0;
      wd_hold_reg <= '0;
      rdv_reg <= `SRAM_LOW;
      rd_reg <= '0;
    end
    else
    begin
      gate_n_reg <= gate_n_next;
      sleep_reg <= sleep_next;
      sel_reg <= sel_next;
      we_n_reg <= we_n_next;
      adv_reg <= adv_next;
      addr_reg <= addr_next;
      lanes_reg <= lanes_next;
      last_reg <= last_next;
      wr_ph_reg <= wr_ph_next;
      rd_ph_reg <= rd_ph_next;
      wd_reg <= wd_next;
      wd_hold_reg <= wd_hold_next;
      rdv_reg <= rdv_next;
      rd_reg <= rd_next;
    end
  end

  assign link.clock_gate_n = gate_n_reg;
  assign link.chip_select_first_n = !sel_reg;
  assign link.chip_select_second = sel_reg;
  assign link.chip_select_third_n = !sel_reg;
  assign link.write_n = we_n_reg;
  assign link.advance_or_load = adv_reg;
  assign link.addr = addr_reg;
  assign link.byte_lane_write_n = lanes_reg;
  assign link.sleep_request = sleep_reg;
  assign link.burst_interleave = i_interleave;
  assign link.output_enable_n = i_out_en_n;
  assign link.host_dq_out = wd_reg;
  assign link.host_dq_oe = wr_ph_reg;
  assign o_rd_valid = rdv_reg;
  assign o_rd_data = rd_reg;
endmodule
`default_nettype wire

// ### sram_device_end.sv
// Memory end: flow-through burst static memory with registered inputs
// Behaviour
// - All synchronous inputs registered on rising edge.
// - Gate high ignores edge, state holds.
// - Reads and writes back to back, no gaps.
// - Write only lanes whose strobes are active.
// - Writes complete internally, no extra strobes.
// - Selected only with all three selects active.
// - Drivers off during write data phase.
// - Low two address bits load burst counter.
// - Linear or interleaved order by mode input.
// - Lane strobes active low, qualified by write.
// - Write strobe low on qualified edge writes.
// - Output drive self timed; enable only gates.
// - Address sampled on edge starting access.
// - Low power when asleep or deselected.
// - Read data flows from array, no register.
// - Sized as 1M x 36 or 2M x 18.
// - Advance high steps counter, low loads address.
// - Outputs off on write, deselect, sleep.
// - Gate does not deselect the device.
// - Sleep input keeps data, low is normal.
`timescale 1ns/1ps
`default_nettype none
`include "sram_link_map.svh"
module sram_device_end
  import sram_link_pkg::*;
#(
  // 36-bit words over 20 address bits, or 18-bit words over 21
  parameter int AW = `SRAM_ADDR_W,
  parameter int DW = `SRAM_DATA_W,
  parameter int LANES = `SRAM_LANES
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  sram_link_if.device link,
  output logic o_low_power,
  output logic [`SRAM_CNT_W-1:0] o_burst_beat
);
  localparam int LW = DW / LANES;
  localparam int DEPTH = 1 << AW;
  localparam int CW = `SRAM_CNT_W;

  logic [DW-1:0] mem [DEPTH];
  op_type op_reg, op_next;
  logic [AW-1:CW] hi_reg, hi_next;
  logic [CW-1:0] base_reg, base_next, beat_reg, beat_next, lo;
  logic [LANES-1:0] lanes_reg, lanes_next;
  logic lp_reg, lp_next;
  logic qual, selected, wr_fire;
  logic load_edge, step_edge;
  logic [AW-1:0] cur_addr;

  // The gate pin is sampled like any other synchronous input
  assign qual = !link.clock_gate_n;
  assign selected = !link.chip_select_first_n && link.chip_select_second
                    && !link.chip_select_third_n;

  // Burst order; both wrap inside the four-word group
  always_comb
  begin
    if (link.burst_interleave)
    begin
      lo = base_reg ^ beat_reg;
    end
    else
    begin
      lo = base_reg + beat_reg;
    end
  end

  assign cur_addr = {hi_reg, lo};

  // Command group: operation, upper address and lane strobes
  always_comb
  begin
    op_next = op_reg;
    hi_next = hi_reg;
    lanes_next = lanes_reg;
    // Without a qualified edge nothing moves, the selection included
    if (qual)
    begin
      if (link.sleep_request)
      begin
        op_next = OP_IDLE;
        lanes_next = '1;
      end
      else if (link.advance_or_load)
      begin
        // Continue the current burst; the write strobe is not looked at
        lanes_next = link.byte_lane_write_n;
      end
      else if (selected)
      begin
        op_next = link.write_n ? OP_READ : OP_WRITE;
        hi_next = link.addr[AW-1:CW];
        lanes_next = link.write_n ? '1 : link.byte_lane_write_n;
      end
      else
      begin
        op_next = OP_IDLE;
        lanes_next = '1;
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      op_reg <= OP_IDLE;
      hi_reg <= '0;
      lanes_reg <= '1;
    end
    else
    begin
      op_reg <= op_next;
      hi_reg <= hi_next;
      lanes_reg <= lanes_next;
    end
  end

  // Burst counter group; an advance while idle leaves it alone
  assign load_edge = qual && !link.sleep_request && !link.advance_or_load && selected;
  assign step_edge = qual && !link.sleep_request && link.advance_or_load
                     && (op_reg != OP_IDLE);

  always_comb
  begin
    base_next = base_reg;
    beat_next = beat_reg;
    if (load_edge)
    begin
      base_next = link.addr[CW-1:0];
      beat_next = `SRAM_CNT_ZERO;
    end
    else if (step_edge)
    begin
      // Two bits roll over on their own, so a burst wraps after four
      beat_next = beat_reg + `SRAM_CNT_STEP;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      base_reg <= `SRAM_CNT_ZERO;
      beat_reg <= `SRAM_CNT_ZERO;
    end
    else
    begin
      base_reg <= base_next;
      beat_reg <= beat_next;
    end
  end

  // Power flag group; it only moves on a qualified edge
  always_comb
  begin
    lp_next = lp_reg;
    if (qual)
    begin
      lp_next = link.sleep_request
                || (!link.advance_or_load && !selected)
                || (link.advance_or_load && op_reg == OP_IDLE);
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      lp_reg <= `SRAM_HIGH;
    end
    else
    begin
      lp_reg <= lp_next;
    end
  end

  // Write data arrives one qualified edge after its command and is
  // committed on that same edge, so no hold cycle is ever needed.
  assign wr_fire = qual && (op_reg == OP_WRITE);

  // Array stays unreset so contents survive sleep and deselect
  always_ff @(posedge i_clk)
  begin
    for (int i = 0; i < LANES; i++)
    begin
      if (wr_fire && !lanes_reg[i])
      begin
        mem[cur_addr][i*LW +: LW] <= link.dq[i*LW +: LW];
      end
    end
  end

  // Flow-through: the registered address reads the array directly.
  // The cost is a longer clock-to-data path than a pipelined part.
  assign link.dev_dq_out = mem[cur_addr];

  // Self-timed drive; the enable pin can only take drive away
  assign link.dev_dq_oe = (op_reg == OP_READ) && !link.output_enable_n
                          && !link.sleep_request;

  assign o_low_power = lp_reg;
  assign o_burst_beat = beat_reg;
endmodule
`default_nettype wire

// ### flow_through_burst_sram_port_checker.sv
// Protocol assertions on the pins between controller and memory
`timescale 1ns/1ps
`default_nettype none
`include "sram_link_map.svh"
module flow_through_burst_sram_port_checker #(
  parameter int DW = `SRAM_DATA_W
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic clock_gate_n,
  input wire logic chip_select_first_n,
  input wire logic chip_select_second,
  input wire logic chip_select_third_n,
  input wire logic write_n,
  input wire logic advance_or_load,
  input wire logic output_enable_n,
  input wire logic sleep_request,
  input wire logic host_dq_oe,
  input wire logic [DW-1:0] dev_dq_out,
  input wire logic dev_dq_oe
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);
  logic sel;
  logic load;
  assign sel = !chip_select_first_n && chip_select_second && !chip_select_third_n;
  // Load only on a qualified edge; advance beats keep the earlier op
  assign load = !clock_gate_n && !advance_or_load;

  chk_write_drive_off: assert property (load && sel && !write_n |=> !dev_dq_oe)
    else $error("device drove data in a write phase");
  chk_read_flow_out: assert property (load && sel && write_n && !sleep_request
    |=> dev_dq_oe || sleep_request || output_enable_n)
    else $error("read data not driven in the cycle after load");
  chk_deselect_quiet: assert property (load && !sel |=> !dev_dq_oe)
    else $error("deselected device drove data");
  chk_stall_holds: assert property (clock_gate_n |=> $stable(dev_dq_out))
    else $error("masked edge changed read data");
  chk_no_contention: assert property (!(dev_dq_oe && host_dq_oe))
    else $error("both ends drove the data wire");
  chk_write_data_phase: assert property (load && sel && !write_n |=> host_dq_oe)
    else $error("controller missed the write data phase");
  chk_oe_gates_drive: assert property (output_enable_n |-> !dev_dq_oe)
    else $error("drive ignored the output enable");
  chk_sleep_quiet: assert property (sleep_request |-> !dev_dq_oe)
    else $error("sleeping device drove data");

  cov_read: cover property (load && sel && write_n ##1 dev_dq_oe);
  cov_write: cover property (load && sel && !write_n ##1 host_dq_oe);
  cov_stall: cover property (clock_gate_n [*3]);
  cov_burst: cover property (!clock_gate_n && advance_or_load);
endmodule
`default_nettype wire

// ### flow_through_burst_sram_port_test.sv
// Self-checking bench joining both ends of the burst memory link
`timescale 1ns/1ps
`default_nettype none
`include "sram_link_map.svh"
module flow_through_burst_sram_port_test;
  logic i_clk = 1'h0;
  logic i_sys_rst = 1'h1;
  logic i_req_valid = 1'h0;
  logic i_req_write = 1'h0;
  logic i_req_burst = 1'h0;
  logic [`SRAM_ADDR_W-1:0] i_req_addr = '0;
  logic [`SRAM_DATA_W-1:0] i_req_data = '0;
  logic [`SRAM_LANES-1:0] i_req_lanes_n = '1;
  logic i_hold = 1'h0;
  logic i_sleep = 1'h0;
  logic i_interleave = 1'h0;
  logic i_out_en_n = 1'h0;
  logic o_req_ready;
  logic o_rd_valid;
  logic [`SRAM_DATA_W-1:0] o_rd_data;
  logic o_low_power;
  int err_count = 0;
  int checked = 0;

  always #2 i_clk = ~i_clk;

  sram_link_if sram_link_if_inst ();
  sram_host_end sram_host_end_inst (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .link(sram_link_if_inst.host),
    .i_req_valid(i_req_valid), .o_req_ready(o_req_ready), .i_req_write(i_req_write),
    .i_req_burst(i_req_burst), .i_req_addr(i_req_addr), .i_req_data(i_req_data),
    .i_req_lanes_n(i_req_lanes_n), .i_hold(i_hold), .i_sleep(i_sleep),
    .i_interleave(i_interleave), .i_out_en_n(i_out_en_n), .o_rd_valid(o_rd_valid),
    .o_rd_data(o_rd_data));
  sram_device_end sram_device_end_inst (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .link(sram_link_if_inst.device),
    .o_low_power(o_low_power), .o_burst_beat());
  flow_through_burst_sram_port_checker flow_through_burst_sram_port_checker_inst (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .clock_gate_n(sram_link_if_inst.clock_gate_n),
    .chip_select_first_n(sram_link_if_inst.chip_select_first_n),
    .chip_select_second(sram_link_if_inst.chip_select_second),
    .chip_select_third_n(sram_link_if_inst.chip_select_third_n),
    .write_n(sram_link_if_inst.write_n), .advance_or_load(sram_link_if_inst.advance_or_load),
    .output_enable_n(sram_link_if_inst.output_enable_n),
    .sleep_request(sram_link_if_inst.sleep_request),
    .host_dq_oe(sram_link_if_inst.host_dq_oe), .dev_dq_out(sram_link_if_inst.dev_dq_out),
    .dev_dq_oe(sram_link_if_inst.dev_dq_oe));

  task automatic finish_test();
    $display("mismatches %0d, comparisons %0d", err_count, checked);
    if (err_count == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic timeout();
    err_count++;
    $display("unexpected wait: expected event, seen timeout");
    finish_test();
  endtask

  task automatic cmp(input string name, input logic [`SRAM_DATA_W-1:0] exp,
    input logic [`SRAM_DATA_W-1:0] got);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask

  // Leaves valid high so back-to-back pushes need no idle cycle
  task automatic push(input logic wr, input logic bu, input logic [`SRAM_ADDR_W-1:0] a,
    input logic [`SRAM_DATA_W-1:0] d, input logic [`SRAM_LANES-1:0] ln);
    int n = 0;
    i_req_valid = 1'h1;
    i_req_write = wr;
    i_req_burst = bu;
    i_req_addr = a;
    i_req_data = d;
    i_req_lanes_n = ln;
    while (o_req_ready !== 1'h1)
    begin
      @(posedge i_clk);
      #1;
      n++;
      if (n > 200)
        timeout();
    end
    @(posedge i_clk);
    #1;
  endtask

  task automatic get(input logic [`SRAM_DATA_W-1:0] exp);
    int n = 0;
    i_req_valid = 1'h0;
    while (o_rd_valid !== 1'h1)
    begin
      @(posedge i_clk);
      #1;
      n++;
      if (n > 200)
        timeout();
    end
    cmp("read data", exp, o_rd_data);
  endtask

  task automatic rd(input logic [`SRAM_ADDR_W-1:0] a, input logic [`SRAM_DATA_W-1:0] exp);
    push(1'h0, 1'h0, a, '0, 4'hf);
    get(exp);
  endtask

  initial
  begin
    logic [`SRAM_ADDR_W-1:0] base;
    repeat (12) @(posedge i_clk);
    #1;
    i_sys_rst = 1'h0;
    push(1'h1, 1'h0, 20'h10, 36'h123456789, 4'h0);
    rd(20'h10, 36'h123456789);
    push(1'h1, 1'h0, 20'h11, 36'hfffffffff, 4'h0);
    push(1'h1, 1'h0, 20'h11, 36'h0, 4'ha);
    rd(20'h11, 36'hff803fe00);
    // Queue a whole burst under stall so its beats leave back to back
    for (int m = 0; m < 2; m++)
    begin
      base = m ? 20'h31 : 20'h22;
      i_interleave = m[0];
      i_hold = 1'h1;
      repeat (2) @(posedge i_clk);
      #1;
      for (int k = 0; k < 4; k++)
        push(1'h1, k != 0, base, 36'h100 + 36'(k), 4'h0);
      cmp("ready when full", 36'h0, {35'h0, o_req_ready});
      i_hold = 1'h0;
      for (int k = 0; k < 4; k++)
        rd(m ? {base[19:2], base[1:0] ^ 2'(k)} : {base[19:2], base[1:0] + 2'(k)},
          36'h100 + 36'(k));
    end
    push(1'h0, 1'h0, 20'h10, '0, 4'hf);
    i_req_valid = 1'h0;
    i_hold = 1'h1;
    repeat (4) @(posedge i_clk);
    #1;
    i_hold = 1'h0;
    get(36'h123456789);
    // Gated drive leaves the wire undriven, which reads as zero
    i_out_en_n = 1'h1;
    rd(20'h10, 36'h0);
    i_out_en_n = 1'h0;
    i_sleep = 1'h1;
    repeat (8) @(posedge i_clk);
    #1;
    cmp("low power", 36'h1, {35'h0, o_low_power});
    // A request queued in sleep waits, then reads the retained word
    push(1'h0, 1'h0, 20'h11, '0, 4'hf);
    i_sleep = 1'h0;
    get(36'hff803fe00);
    finish_test();
  end
endmodule
`default_nettype wire
